// File: verilog/fgle_pkg.sv
package fgle_pkg;

  // ****************************************************************
  // Register map, byte addresses on the register bus.
  // ****************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00; // Enables and flags.
  localparam logic [7:0] REG_DIRBASE = 8'h04; // Bus lock control.
  localparam logic [7:0] REG_PMASK = 8'h08; // Pixel mask.
  localparam logic [7:0] REG_ACC_LO = 8'h0C; // Accumulator low word.
  localparam logic [7:0] REG_ACC_HI = 8'h10; // Accumulator high word.
  localparam logic [2:0] IDX_LAST = 3'h4; // Highest register index.

  // Field positions inside the status and lock registers.
  localparam int ST_IE_BIT = 0; // Interrupt enable.
  localparam int ST_OVF_BIT = 1; // overflow_flag.
  localparam int ST_ITRAP_BIT = 2; // instruction_trap_flag, W1C.
  localparam int DB_BL_BIT = 0; // bus_lock_bit.
  localparam int DB_LOCKED_BIT = 1; // Bus currently locked, RO.

  // Exponent biases and fixed values used by the float arithmetic.
  localparam logic [12:0] SGL_BIAS = 13'h007F; // Single bias.
  localparam logic [12:0] DBL_BIAS = 13'h03FF; // Double bias.
  localparam logic [31:0] RSQ_ONE = 32'h1000_0000; // 1.0 at 2^28.
  localparam logic [31:0] TRUNC_OVF = 32'h8000_0000; // Out of range.

  // Access sizes: 8, 16, 32 and 64 bits.
  localparam logic [1:0] SZ_8 = 2'h0; // Byte.
  localparam logic [1:0] SZ_16 = 2'h1; // Half word.
  localparam logic [1:0] SZ_32 = 2'h2; // Word.

  // Bus spaces.
  localparam logic [1:0] SP_MEM = 2'h0; // Memory.
  localparam logic [1:0] SP_IO = 2'h1; // I/O ports.
  localparam logic [1:0] SP_VEC = 2'h2; // Interrupt vector.

  // Operations accepted by the unit.
  typedef enum logic [3:0] {
    OP_LONG_ADD, OP_FMUL, OP_RSQRT, OP_TRUNC, OP_ZCHK32, OP_ZCHK16,
    OP_OR_ACCUMULATOR_A, OP_FLOAD, OP_FSTORE, OP_OVF_TRAP, OP_CTRL_LOAD,
    OP_INT_LOAD, OP_VEC_LOAD, OP_IO_LOAD, OP_LOCK
  } fgle_op_t;

  typedef enum logic {ST_IDLE, ST_MEM} fgle_state_t;

  // Whole state of the unit.
  typedef struct packed {
    fgle_state_t state; // Sequencer.
    logic busy; // Unit occupied.
    logic done; // Operation finished.
    logic trap; // Trap raised.
    logic idest_we; // Integer write.
    logic [31:0] idest; // Integer result.
    logic fdest_we; // Float write.
    logic [63:0] fdest; // Float result.
    logic isrc2_we; // Autoincrement write.
    logic [31:0] isrc2; // Autoincrement value.
    logic mem_req; // Bus request.
    logic mem_we; // Bus write.
    logic [1:0] mem_space; // Bus space.
    logic [1:0] mem_size; // Access size.
    logic [31:0] mem_addr; // Bus address.
    logic [63:0] mem_wdata; // Store data.
    logic to_fdest; // Load target is float file.
    logic autoinc; // Autoincrement form.
    logic ie; // Interrupt enable.
    logic ovf; // overflow_flag.
    logic itrap; // instruction_trap_flag.
    logic bl; // bus_lock_bit.
    logic locked; // Bus held locked.
    logic intok; // Interrupts allowed.
    logic [7:0] pm; // pixel_mask.
    logic [63:0] acc; // accumulator_a.
    logic pready; // Bus answer.
    logic pslverr; // Bus error.
    logic [31:0] prdata; // Read data.
  } fgle_st_t;

  localparam fgle_st_t ST_RST = '0; // Value after reset.

endpackage

// File: verilog/fgle_exec.sv
`timescale 1ns/1ps

module fgle_exec import fgle_pkg::*; (
  input wire logic i_ref_clk, // Processor clock.
  input wire logic i_reset, // Synchronous reset.
  input wire logic i_op_valid, // Operation offered.
  input wire fgle_op_t i_op, // Operation code.
  input wire logic i_dbl, // Double precision.
  input wire logic [1:0] i_size, // Access size.
  input wire logic i_autoinc, // Autoincrement form.
  input wire logic [2:0] i_ctrl_sel, // Control register index.
  input wire logic [31:0] i_isrc1, // Integer source 1.
  input wire logic [31:0] i_isrc2, // Integer source 2.
  input wire logic [63:0] i_fsrc1, // Float source 1.
  input wire logic [63:0] i_fsrc2, // Float source 2.
  output logic o_busy, // Unit occupied.
  output logic o_done, // Operation done pulse.
  output logic o_trap, // Trap pulse.
  output logic o_idest_we, // Integer write pulse.
  output logic [31:0] o_idest, // Integer result.
  output logic o_fdest_we, // Float write pulse.
  output logic [63:0] o_fdest, // Float result.
  output logic o_isrc2_we, // Autoincrement pulse.
  output logic [31:0] o_isrc2, // Autoincrement value.
  output logic o_mem_req, // Bus request level.
  output logic o_mem_we, // Bus write.
  output logic [1:0] o_mem_space, // Bus space.
  output logic [1:0] o_mem_size, // Access size.
  output logic [31:0] o_mem_addr, // Bus address.
  output logic [63:0] o_mem_wdata, // Store data.
  output logic o_mem_lock, // Locked cycle.
  input wire logic i_mem_ack, // Bus done.
  input wire logic [63:0] i_mem_rdata, // Load data.
  output logic o_int_enable, // Interrupts allowed.
  input wire logic i_psel, // APB select.
  input wire logic i_penable, // APB enable.
  input wire logic i_pwrite, // APB write.
  input wire logic [7:0] i_paddr, // APB address.
  input wire logic [31:0] i_pwdata, // APB write data.
  output logic [31:0] o_prdata, // APB read data.
  output logic o_pready, // APB ready.
  output logic o_pslverr // APB error.
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Reads register by index; shared by the bus and control load.
  function automatic logic [31:0] rd_reg(fgle_st_t s, logic [2:0] ix);
    logic [31:0] v;
    v = '0;
    if (ix == REG_STATUS[4:2]) begin
      v[ST_IE_BIT] = s.ie;
      v[ST_OVF_BIT] = s.ovf;
      v[ST_ITRAP_BIT] = s.itrap;
    end else if (ix == REG_DIRBASE[4:2]) begin
      v[DB_BL_BIT] = s.bl;
      v[DB_LOCKED_BIT] = s.locked;
    end else if (ix == REG_PMASK[4:2]) begin
      v[7:0] = s.pm;
    end else if (ix == REG_ACC_LO[4:2]) begin
      v = s.acc[31:0];
    end else if (ix == REG_ACC_HI[4:2]) begin
      v = s.acc[63:32];
    end
    return v;
  endfunction

  // Keeps only the bytes of the selected access size.
  function automatic logic [63:0] szmask(logic [63:0] d, logic [1:0] z);
    logic [63:0] v;
    v = d;
    if (z == SZ_8) begin
      v = {56'h0, d[7:0]};
    end else if (z == SZ_16) begin
      v = {48'h0, d[15:0]};
    end else if (z == SZ_32) begin
      v = {32'h0, d[31:0]};
    end
    return v;
  endfunction

  // Product with truncated mantissa; zero exponent reads as zero.
  // Overflow and special values are not handled, to keep it small.
  function automatic logic [63:0] fmul(logic [63:0] a, logic [63:0] b,
                                       logic d);
    logic [52:0] ma;
    logic [52:0] mb;
    logic [105:0] p;
    logic [12:0] e;
    logic [51:0] f;
    logic s;
    logic z;
    if (d) begin
      s = a[63] ^ b[63];
      ma = {1'b1, a[51:0]};
      mb = {1'b1, b[51:0]};
      e = {2'h0, a[62:52]} + {2'h0, b[62:52]} - DBL_BIAS;
      z = (a[62:52] == 11'h000) || (b[62:52] == 11'h000);
    end else begin
      s = a[31] ^ b[31];
      ma = {1'b1, a[22:0], 29'h0};
      mb = {1'b1, b[22:0], 29'h0};
      e = {5'h00, a[30:23]} + {5'h00, b[30:23]} - SGL_BIAS;
      z = (a[30:23] == 8'h00) || (b[30:23] == 8'h00);
    end
    p = ma * mb;
    if (p[105]) begin
      f = p[104:53];
      e = e + 13'h0001;
    end else begin
      f = p[103:52];
    end
    if (z) begin
      fmul = d ? {s, 63'h0} : {32'h0, s, 31'h0};
    end else begin
      fmul = d ? {s, e[10:0], f} : {32'h0, s, e[7:0], f[51:29]};
    end
  endfunction

  // Bitwise search for the largest r with r*r*m <= 1.0; r carries
  // nine fraction bits, so the relative error stays near 2^-8.
  function automatic logic [63:0] rsqrt(logic [63:0] a, logic d);
    logic signed [12:0] u;
    logic [11:0] m;
    logic [9:0] r;
    logic [9:0] t;
    logic [31:0] pr;
    logic signed [12:0] ye;
    logic [7:0] fr;
    u = d ? $signed({2'h0, a[62:52]} - DBL_BIAS)
          : $signed({5'h00, a[30:23]} - SGL_BIAS);
    m = d ? {2'h1, a[51:42]} : {2'h1, a[22:13]};
    if (u[0]) begin
      m = {m[10:0], 1'b0};
      u = u - 13'sh0001;
    end
    r = '0;
    for (int k = 9; k >= 0; k--) begin
      t = r | (10'h001 << k);
      pr = {22'h0, t} * {22'h0, t} * {20'h0, m};
      if (pr <= RSQ_ONE) begin
        r = t;
      end
    end
    ye = -(u >>> 1) - (r[9] ? 13'sh0000 : 13'sh0001);
    fr = r[9] ? 8'h00 : r[7:0];
    if (d) begin
      rsqrt = {1'b0, 11'(ye + $signed(DBL_BIAS)), fr, 44'h0};
    end else begin
      rsqrt = {32'h0, 1'b0, 8'(ye + $signed(SGL_BIAS)), fr, 15'h0};
    end
  endfunction

  // Drops the fraction; values beyond 31 bits give the marker.
  function automatic logic [63:0] trunc(logic [63:0] a, logic d);
    logic signed [12:0] u;
    logic [52:0] m;
    logic [31:0] v;
    u = d ? $signed({2'h0, a[62:52]} - DBL_BIAS)
          : $signed({5'h00, a[30:23]} - SGL_BIAS);
    m = d ? {1'b1, a[51:0]} : {1'b1, a[22:0], 29'h0};
    if (u < 13'sh0000) begin
      v = '0;
    end else if (u > 13'sh001E) begin
      v = TRUNC_OVF;
    end else begin
      v = 32'(m >> (6'd52 - 6'(u)));
    end
    if ((d ? a[63] : a[31]) && (v != TRUNC_OVF)) begin
      v = -v;
    end
    return {{32{v[31]}}, v};
  endfunction

  // Z-check on 32-bit (w16 low) or 16-bit fields; result is
  // {new mask, smaller fields}.
  function automatic logic [71:0] zchk(logic [63:0] a, logic [63:0] b,
                                       logic [7:0] pm, logic w16);
    logic [7:0] nm;
    logic [63:0] r;
    r = '0;
    if (w16) begin
      nm = pm >> 4;
      for (int i = 0; i < 4; i++) begin
        nm[i + 4] = b[16*i +: 16] <= a[16*i +: 16];
        r[16*i +: 16] = nm[i + 4] ? b[16*i +: 16] : a[16*i +: 16];
      end
    end else begin
      nm = pm >> 2;
      for (int i = 0; i < 2; i++) begin
        nm[i + 6] = b[32*i +: 32] <= a[32*i +: 32];
        r[32*i +: 32] = nm[i + 6] ? b[32*i +: 32] : a[32*i +: 32];
      end
    end
    return {nm, r};
  endfunction

  // ****************************************************************
  // State and next state.
  // ****************************************************************
  fgle_st_t q; // Registered state.
  fgle_st_t n; // Next state.
  logic take; // Operation accepted this cycle.
  logic [71:0] zr; // Z-check result.

  assign take = i_op_valid && (q.state == ST_IDLE);
  assign zr = zchk(i_fsrc1, i_fsrc2, q.pm, i_op == OP_ZCHK16);

  // Next-state logic: bus slave first, then execution, so that a
  // flag set by hardware wins over a clear by software.
  always_comb begin
    n = q;
    n.done = 1'b0;
    n.trap = 1'b0;
    n.idest_we = 1'b0;
    n.fdest_we = 1'b0;
    n.isrc2_we = 1'b0;
    n.pready = 1'b0;
    // Setup cycle: read data and error are prepared for access.
    if (i_psel && !i_penable) begin
      n.pready = 1'b1;
      n.pslverr = (i_paddr[1:0] != 2'h0) || (i_paddr[7:2] > IDX_LAST);
      n.prdata = n.pslverr ? 32'h0000_0000 : rd_reg(q, i_paddr[4:2]);
    end
    // Access cycle: a write takes effect at this edge only.
    if (i_psel && i_penable && q.pready && i_pwrite && !q.pslverr) begin
      if (i_paddr == REG_STATUS) begin
        n.ie = i_pwdata[ST_IE_BIT];
        n.ovf = i_pwdata[ST_OVF_BIT];
        if (i_pwdata[ST_ITRAP_BIT]) begin
          n.itrap = 1'b0;
        end
      end else if (i_paddr == REG_DIRBASE) begin
        n.bl = i_pwdata[DB_BL_BIT];
      end else if (i_paddr == REG_PMASK) begin
        n.pm = i_pwdata[7:0];
      end else if (i_paddr == REG_ACC_LO) begin
        n.acc[31:0] = i_pwdata;
      end else begin
        n.acc[63:32] = i_pwdata;
      end
    end
    case (q.state)
      ST_IDLE: begin
        if (i_op_valid) begin
          n.done = 1'b1;
          case (i_op)
            OP_LONG_ADD: begin
              n.fdest_we = 1'b1;
              n.fdest = i_fsrc1 + i_fsrc2;
            end
            OP_FMUL: begin
              n.fdest_we = 1'b1;
              n.fdest = fmul(i_fsrc1, i_fsrc2, i_dbl);
            end
            OP_RSQRT: begin
              n.fdest_we = 1'b1;
              n.fdest = rsqrt(i_fsrc2, i_dbl);
            end
            OP_TRUNC: begin
              n.fdest_we = 1'b1;
              n.fdest = trunc(i_fsrc1, i_dbl);
            end
            OP_ZCHK32, OP_ZCHK16: begin
              n.fdest_we = 1'b1;
              n.pm = zr[71:64];
              n.fdest = zr[63:0];
              n.acc = '0;
            end
            OP_OR_ACCUMULATOR_A: begin
              n.fdest_we = 1'b1;
              n.fdest = i_fsrc1 | q.acc;
              n.acc = '0;
            end
            OP_OVF_TRAP: begin
              if (q.ovf) begin
                n.trap = 1'b1;
                n.itrap = 1'b1;
              end
            end
            OP_CTRL_LOAD: begin
              n.idest_we = 1'b1;
              n.idest = rd_reg(q, i_ctrl_sel);
            end
            OP_LOCK: begin
              n.bl = 1'b1;
            end
            default: begin
              // Bus operations: the request holds until acknowledged.
              n.done = 1'b0;
              n.state = ST_MEM;
              n.mem_req = 1'b1;
              n.mem_size = i_size;
              n.autoinc = i_autoinc && (i_op inside {OP_FLOAD, OP_FSTORE});
              n.mem_we = (i_op == OP_FSTORE);
              n.mem_wdata = szmask(i_fsrc1, i_size);
              n.to_fdest = (i_op == OP_FLOAD);
              n.mem_addr = i_isrc1 + i_isrc2;
              n.mem_space = SP_MEM;
              if (i_op == OP_VEC_LOAD) begin
                n.mem_addr = i_isrc2;
                n.mem_space = SP_VEC;
              end else if (i_op == OP_IO_LOAD) begin
                n.mem_addr = i_isrc2;
                n.mem_space = SP_IO;
              end
              if (q.bl) begin
                n.locked = 1'b1;
              end
            end
          endcase
        end
      end
      ST_MEM: begin
        if (i_mem_ack) begin
          n.state = ST_IDLE;
          n.mem_req = 1'b0;
          n.done = 1'b1;
          n.isrc2_we = q.autoinc;
          n.isrc2 = q.mem_addr;
          if (!q.mem_we) begin
            n.fdest_we = q.to_fdest;
            n.idest_we = !q.to_fdest;
            n.fdest = szmask(i_mem_rdata, q.mem_size);
            n.idest = n.fdest[31:0];
          end
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
    // Clearing the lock bit releases the bus.
    if (!n.bl) begin
      n.locked = 1'b0;
    end
    n.intok = n.ie && !n.bl && !n.locked;
    n.busy = (n.state != ST_IDLE);
  end

  // One register for the whole state.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register.
  // ****************************************************************
  assign o_busy = q.busy;
  assign o_done = q.done;
  assign o_trap = q.trap;
  assign o_idest_we = q.idest_we;
  assign o_idest = q.idest;
  assign o_fdest_we = q.fdest_we;
  assign o_fdest = q.fdest;
  assign o_isrc2_we = q.isrc2_we;
  assign o_isrc2 = q.isrc2;
  assign o_mem_req = q.mem_req;
  assign o_mem_we = q.mem_we;
  assign o_mem_space = q.mem_space;
  assign o_mem_size = q.mem_size;
  assign o_mem_addr = q.mem_addr;
  assign o_mem_wdata = q.mem_wdata;
  assign o_mem_lock = q.locked;
  assign o_int_enable = q.intok;
  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  AST_LADD: assert property (
    take && i_op == OP_LONG_ADD |=>
      o_fdest_we && o_fdest == $past(i_fsrc1) + $past(i_fsrc2))
    else $error("long add result wrong");
  AST_ORM: assert property (
    take && i_op == OP_OR_ACCUMULATOR_A |=>
      o_fdest == ($past(i_fsrc1) | $past(q.acc)) && q.acc == '0)
    else $error("or with accumulator wrong");
  AST_MADDR: assert property (
    take && i_op inside {OP_FLOAD, OP_FSTORE, OP_INT_LOAD} |=>
      o_mem_req && o_mem_addr == $past(i_isrc1) + $past(i_isrc2))
    else $error("bus address wrong");
  AST_AINC: assert property (
    q.state == ST_MEM && i_mem_ack && q.autoinc |=>
      o_isrc2_we && o_isrc2 == $past(o_mem_addr) && !o_mem_req)
    else $error("autoincrement missing");
  AST_TRAP: assert property (
    take && i_op == OP_OVF_TRAP && q.ovf |=> o_trap && q.itrap)
    else $error("trap not raised");
  AST_NOTRAP: assert property (
    take && i_op == OP_OVF_TRAP && !q.ovf |=> !o_trap)
    else $error("trap raised without overflow");
  AST_LOCK: assert property (
    take && i_op == OP_LOCK |=> q.bl && !o_int_enable)
    else $error("lock did not arm");
  AST_LOCKED: assert property (
    o_mem_lock |-> !o_int_enable)
    else $error("interrupts enabled while locked");
  AST_Z16: assert property (
    take && i_op == OP_ZCHK16 |=>
      q.pm[3:0] == $past(q.pm[7:4]) && q.acc == '0)
    else $error("z-check mask shift wrong");
  AST_HOLD: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("bus request dropped");

  COV_LOCKED: cover property (take && q.bl ##1 o_mem_lock);
  COV_AINC: cover property (o_isrc2_we && o_fdest_we);
  COV_Z32: cover property (take && i_op == OP_ZCHK32);
  COV_APBW: cover property (i_psel && i_penable && o_pready && i_pwrite);

endmodule

// File: verif/fgle_mem_model.sv
`timescale 1ns/1ps

// ****
// Far-side memory, port and vector bus model.
// ****
module fgle_mem_model (
  input wire logic i_ref_clk, // Processor clock.
  input wire logic i_req, // Bus request.
  input wire logic [31:0] i_addr, // Bus address.
  input wire logic [1:0] i_space, // Bus space.
  input wire logic [63:0] i_wdata, // Store data.
  input wire logic [3:0] i_wait, // Wait cycles.
  output logic o_ack, // Bus done.
  output logic [63:0] o_rdata, // Load data.
  output logic [31:0] o_addr, // Address seen.
  output logic [1:0] o_space, // Space seen.
  output logic [63:0] o_wdata // Store data seen.
);
  logic [3:0] cnt = 4'h0; // Cycles waited.

  initial begin
    o_ack = 1'b0;
    o_rdata = 64'h0;
  end

  // Answers after i_wait cycles. Read data mixes space and address,
  // so a wrong address or space shows in the loaded value.
  always @(posedge i_ref_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata; // Idle bus shows junk that flips each cycle.
    if (i_req && !o_ack) begin
      if (cnt == i_wait) begin
        o_ack <= 1'b1;
        o_rdata <= {30'h0, i_space, ~i_addr};
        o_addr <= i_addr;
        o_space <= i_space;
        o_wdata <= i_wdata;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// File: verif/fgle_exec_tb.sv
`timescale 1ns/1ps

// ****
// Self-checking bench for the execution unit.
// ****
module fgle_exec_tb import fgle_pkg::*;;
  logic clk = 0, rst = 1, opv = 0, dbl = 0, ai = 0, tr, sw, pe;
  fgle_op_t op = OP_LONG_ADD;
  logic [1:0] sz = 2'h0;
  logic [2:0] cs = 3'h0;
  logic [31:0] is1 = '0, is2 = '0, pwd = '0, r;
  logic [63:0] f1 = '0, f2 = '0;
  logic psel = 0, pen = 0, pwr = 0;
  logic [7:0] pa = '0;
  logic [3:0] wt = 4'h0;
  logic [1:0] wv; // Float and integer write pulses seen at done.
  int n_fail = 0, checks = 0, cyc = 0;
  wire busy, done, trap, iwe, fwe, s2we, req, mwe, lock, ien;
  wire prdy, perr, ack;
  wire [1:0] msp, msz, lsp;
  wire [31:0] idst, s2, maddr, prd, laddr;
  wire [63:0] fdst, mwd, rdat, lwd;

  fgle_exec dut (.i_ref_clk(clk), .i_reset(rst), .i_op_valid(opv),
    .i_op(op), .i_dbl(dbl), .i_size(sz), .i_autoinc(ai),
    .i_ctrl_sel(cs), .i_isrc1(is1), .i_isrc2(is2), .i_fsrc1(f1),
    .i_fsrc2(f2), .o_busy(busy), .o_done(done), .o_trap(trap),
    .o_idest_we(iwe), .o_idest(idst), .o_fdest_we(fwe),
    .o_fdest(fdst), .o_isrc2_we(s2we), .o_isrc2(s2),
    .o_mem_req(req), .o_mem_we(mwe), .o_mem_space(msp),
    .o_mem_size(msz), .o_mem_addr(maddr), .o_mem_wdata(mwd),
    .o_mem_lock(lock), .i_mem_ack(ack), .i_mem_rdata(rdat),
    .o_int_enable(ien), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr));

  fgle_mem_model mem (.i_ref_clk(clk), .i_req(req), .i_addr(maddr),
    .i_space(msp), .i_wdata(mwd), .i_wait(wt), .o_ack(ack),
    .o_rdata(rdat), .o_addr(laddr), .o_space(lsp), .o_wdata(lwd));

  always #2 clk = ~clk;

  // Cuts a hang short; the whole run needs well under 1000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  // One APB transfer, then an idle cycle so no strobe is set twice
  // in one time step. Read data lands in r, the error flag in pe.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the bench timeout may end this wait.
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    r = prd;
    pe = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Offers one operation and waits for its done pulse.
  task automatic run(input fgle_op_t o);
    int n;
    logic bz;
    logic eb;
    n = 0;
    bz = 1'b0;
    eb = o inside {OP_FLOAD, OP_FSTORE, OP_INT_LOAD, OP_VEC_LOAD,
      OP_IO_LOAD};
    op <= o;
    opv <= 1'b1;
    @(posedge clk);
    opv <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      bz |= busy;
    end while (done !== 1'b1 && n < 40);
    tr = trap;
    sw = s2we;
    wv = {fwe, iwe};
    chk("done", {63'h0, done}, 64'h1);
    // Only bus operations may keep the unit busy while they wait.
    chk("busy", {63'h0, bz}, {63'h0, eb});
  endtask

  task automatic t_fp();
    fgle_op_t o [6] = '{OP_LONG_ADD, OP_FMUL, OP_TRUNC, OP_FMUL, OP_TRUNC,
      OP_TRUNC};
    logic d [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [63:0] a [6] = '{64'h0000_0001_FFFF_FFFF, 64'h4000_0000_0000_0000,
      64'h4014_0000_0000_0000, 64'h4000_0000, 64'h4070_0000, 64'hC020_0000};
    logic [63:0] b [6] = '{64'h1, 64'h4008_0000_0000_0000, 64'h0,
      64'h4040_0000, 64'h0, 64'h0};
    logic [63:0] e [6] = '{64'h0000_0002_0000_0000, 64'h4018_0000_0000_0000,
      64'h5, 64'h40C0_0000, 64'h3, 64'hFFFF_FFFF_FFFF_FFFE};
    // Double cases first, so the single-precision root below keeps dbl low.
    for (int k = 0; k < 6; k++) begin
      f1 <= a[k];
      f2 <= b[k];
      dbl <= d[k];
      run(o[k]);
      chk("fp_result", fdst, e[k]);
      chk("fp_we", {62'h0, wv}, 64'h2);
    end
    f1 <= 64'h0;
    f2 <= 64'h4080_0000;
    run(OP_RSQRT);
    // Result of 0.5 may miss by less than the allowed fraction error.
    chk("rsqrt", {63'h0, (fdst[31:0] - 32'h3EFF_0000) < 32'h0002_0000},
      64'h1);
    $display("arithmetic test done");
  endtask

  task automatic t_accumulator_a();
    apb(1'b1, REG_ACC_LO, 32'h0000_00F0);
    apb(1'b1, REG_ACC_HI, 32'h1234_0000);
    f1 <= 64'hF;
    dbl <= 1'b1;
    run(OP_OR_ACCUMULATOR_A);
    chk("or_accumulator_a", fdst, 64'h1234_0000_0000_00FF);
    apb(1'b0, REG_ACC_HI, 32'h0);
    chk("acc_clear", {32'h0, r}, 64'h0);
    $display("accumulator_a test done");
  endtask

  task automatic t_zchk();
    apb(1'b1, REG_PMASK, 32'h0000_00FF);
    apb(1'b1, REG_ACC_LO, 32'h0000_0001);
    f1 <= 64'h0000_0010_0000_0005;
    f2 <= 64'h0000_0020_0000_0005;
    run(OP_ZCHK32);
    chk("z32_min", fdst, 64'h0000_0010_0000_0005);
    apb(1'b0, REG_PMASK, 32'h0);
    chk("z32_mask", {32'h0, r}, 64'h7F);
    apb(1'b0, REG_ACC_LO, 32'h0);
    chk("z32_acc", {32'h0, r}, 64'h0);
    apb(1'b1, REG_PMASK, 32'h0000_00F0);
    f1 <= 64'h0005_0100_FFFF_0000;
    f2 <= 64'h0006_00FF_0000_0000;
    run(OP_ZCHK16);
    chk("z16_min", fdst, 64'h0005_00FF_0000_0000);
    cs <= 3'h2;
    run(OP_CTRL_LOAD);
    chk("z16_mask", {32'h0, idst}, 64'h7F);
    $display("z-check test done");
  endtask

  task automatic t_trap();
    apb(1'b1, REG_STATUS, 32'h0000_0001);
    run(OP_OVF_TRAP);
    chk("no_trap", {63'h0, tr}, 64'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status_a", {32'h0, r}, 64'h1);
    apb(1'b1, REG_STATUS, 32'h0000_0003);
    run(OP_OVF_TRAP);
    chk("trap", {63'h0, tr}, 64'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status_b", {32'h0, r}, 64'h7);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {31'h0, pe, r}, 64'h1_0000_0000);
    $display("trap test done");
  endtask

  task automatic t_mem();
    wt <= 4'h3;
    is1 <= 32'h0000_0100;
    is2 <= 32'h0000_0020;
    sz <= 2'h3;
    ai <= 1'b1;
    run(OP_FLOAD);
    chk("fld_addr", {32'h0, laddr}, 64'h120);
    chk("fld_data", fdst, 64'hFFFF_FEDF);
    chk("fld_inc", {31'h0, sw, s2}, 64'h1_0000_0120);
    wt <= 4'h0;
    is1 <= 32'h0000_0004;
    is2 <= 32'h0000_0008;
    f1 <= 64'hA5A5_0000_1234_5678;
    f2 <= 64'hA5A5_0000_1234_5678;
    run(OP_FSTORE);
    chk("fst_addr", {32'h0, laddr}, 64'hC);
    chk("fst_data", lwd, 64'hA5A5_0000_1234_5678);
    chk("fst_inc", {31'h0, sw, s2}, 64'h1_0000_000C);
    chk("fst_we", {61'h0, mwe, msz}, 64'h7);
    ai <= 1'b0;
    sz <= SZ_32;
    is1 <= 32'h0000_0999;
    is2 <= 32'h0000_0040;
    run(OP_INT_LOAD);
    chk("ld_int", {32'h0, idst}, 64'hFFFF_F626);
    chk("ld_we", {62'h0, wv}, 64'h1);
    // The port read is a half word, the vector read a single byte.
    for (int k = 0; k < 2; k++) begin
      sz <= k ? SZ_8 : SZ_16;
      run(k ? OP_VEC_LOAD : OP_IO_LOAD);
      chk("sp", 64'(lsp), 64'(k ? SP_VEC : SP_IO));
      chk("pdata", {32'h0, idst}, k ? 64'hBF : 64'hFFBF);
    end
    $display("memory test done");
  endtask

  task automatic t_lock();
    chk("ie_on", {63'h0, ien}, 64'h1);
    run(OP_LOCK);
    apb(1'b0, REG_DIRBASE, 32'h0);
    chk("bl_set", {32'h0, r}, 64'h1);
    chk("ie_off", {63'h0, ien}, 64'h0);
    wt <= 4'h2;
    run(OP_INT_LOAD);
    apb(1'b0, REG_DIRBASE, 32'h0);
    chk("locked", {31'h0, lock, r}, 64'h1_0000_0003);
    apb(1'b1, REG_DIRBASE, 32'h0);
    apb(1'b0, REG_DIRBASE, 32'h0);
    chk("unlock", {31'h0, ien, r}, 64'h1_0000_0000);
    $display("lock test done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_fp();
    t_accumulator_a();
    t_zchk();
    t_trap();
    t_mem();
    t_lock();
    end_sim();
  end
endmodule
